// ---- rtl/fvs_status_one.sv ----
// Volatile status register one with its command gating.
// Assumes a link front end on clk_link that decodes whole commands and
// an array engine on clk_sys that runs and reports embedded operations.
`timescale 1ns/1ns

module fvs_status_one
	import fvs_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       clk_link,
	// Link side, clk_link domain
	input  wire logic       cmd_valid,
	input  wire fvs_cmd_t   cmd_in,
	output logic            cmd_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	// Persistent bits and pins, clk_sys domain except wp_n_pin, which is synchronised here
	input  wire logic       status_write_lock_persistent,
	input  wire logic [2:0] protect_bits_persistent,
	input  wire logic       protect_bits_volatile_select,
	input  wire logic       busy_default,
	input  wire logic       wp_n_pin,
	// Array engine, clk_sys domain
	input  wire logic       op_done,
	input  wire logic       op_fail,
	input  wire logic       op_prot_skip,
	output logic            op_start,
	output fvs_kind_t       op_kind,
	output logic [7:0]      op_data,
	output logic            op_to_sr1,
	output logic            susp_erase,
	output logic            susp_prog,
	output logic [2:0]      protect_active,
	output logic [7:0]      status1_volatile
);

	// ----------------------------------------------------------------
	// Link domain: command hold and toggle handshake
	// ----------------------------------------------------------------
	logic       lk_req_q;   // Toggles once per command
	fvs_cmd_t   lk_cmd_q;   // Held stable until acknowledged
	logic       lk_ack_s1;  // Sync stage one
	logic       lk_ack_s2;  // Sync stage two
	logic       lk_ack_s3;  // Edge detect stage
	logic       rsp_valid_q;
	logic [7:0] rsp_data_q;

	// Sys domain handshake
	logic       sy_req_s1;
	logic       sy_req_s2;
	logic       sy_req_s3;
	logic       sy_ack_q;
	logic [7:0] sy_rsp_q;   // Held for the link to pick up

	// Ready only once the previous answer has been taken over
	assign cmd_ready = (lk_req_q == lk_ack_s3);

	// Capture command and raise request
	always_ff @(posedge clk_link or negedge rst_n) begin
		if (!rst_n) begin
			lk_req_q <= RST_FLAG;
			lk_cmd_q <= '0;
		end else if (cmd_valid && cmd_ready) begin
			lk_req_q <= ~lk_req_q;
			lk_cmd_q <= cmd_in;
		end
	end

	// Acknowledge synchroniser
	always_ff @(posedge clk_link or negedge rst_n) begin
		if (!rst_n) begin
			lk_ack_s1 <= RST_FLAG;
			lk_ack_s2 <= RST_FLAG;
			lk_ack_s3 <= RST_FLAG;
		end else begin
			lk_ack_s1 <= sy_ack_q;
			lk_ack_s2 <= lk_ack_s1;
			lk_ack_s3 <= lk_ack_s2;
		end
	end

	// Answer word: stable in sys domain while the ack edge travels
	always_ff @(posedge clk_link or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_q <= RST_FLAG;
			rsp_data_q  <= RST_BYTE;
		end else begin
			rsp_valid_q <= lk_ack_s2 ^ lk_ack_s3;
			if (lk_ack_s2 ^ lk_ack_s3) begin
				rsp_data_q <= sy_rsp_q;
			end
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp_data  = rsp_data_q;

	// ----------------------------------------------------------------
	// Sys domain: request synchroniser and pin synchroniser
	// ----------------------------------------------------------------
	logic wp_s1;
	logic wp_s2;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sy_req_s1 <= RST_FLAG;
			sy_req_s2 <= RST_FLAG;
			sy_req_s3 <= RST_FLAG;
			wp_s1     <= RST_FLAG;
			wp_s2     <= RST_FLAG;
		end else begin
			sy_req_s1 <= lk_req_q;
			sy_req_s2 <= sy_req_s1;
			sy_req_s3 <= sy_req_s2;
			wp_s1     <= wp_n_pin;
			wp_s2     <= wp_s1;
		end
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic       lock_q;     // Mirror of persistent lock
	logic       p_err_q;    // Program failure flag
	logic       e_err_q;    // Erase failure flag
	logic [2:0] prot_q;     // Volatile protection level
	logic       wel_q;      // Write enable latch
	logic       init_q;     // Post-reset defaults loaded
	fvs_state_t state_q;    // Busy engine
	fvs_kind_t  kind_q;     // Kind of running operation
	logic       busy;

	assign busy = (state_q != ST_IDLE);

	// Live view of every field
	assign status1_volatile = {lock_q, p_err_q, e_err_q, prot_q,
		wel_q, busy};

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Commands that still pass while busy
	function automatic logic busy_ok(input logic [7:0] op);
		busy_ok = (op == OP_READ_STAT1) || (op == OP_READ_STAT2) ||
			(op == OP_READ_ANY) || (op == OP_ERASE_SUSP) ||
			(op == OP_PROG_SUSP) || (op == OP_CLEAR_STAT_A) ||
			(op == OP_CLEAR_STAT_B) || (op == OP_SOFT_RESET);
	endfunction

	fvs_cmd_t   cmd;
	logic [7:0] op;
	logic [2:0] prot_eff;
	logic       new_cmd;
	logic       accept;
	logic       is_wr;
	logic       is_pgm;
	logic       is_ers;
	logic       is_be;
	logic       go;
	logic       wr_go;
	logic       wr_vol;
	logic       wr_nv;
	logic       pgm_bad;
	logic       ers_bad;
	logic       pgm_go;
	logic       ers_go;
	logic       be_go;
	logic       clr_stat;
	logic       soft_rst;
	logic       done_ok;

	// Held by the link side for the whole handshake
	assign cmd     = lk_cmd_q;
	assign op      = cmd.op;
	assign new_cmd = sy_req_s2 ^ sy_req_s3;

	// Protection level in force
	assign prot_eff = protect_bits_volatile_select ? prot_q
		: protect_bits_persistent;
	assign protect_active = prot_eff;

	assign accept = new_cmd && (!busy || busy_ok(op));
	assign is_wr  = (op == OP_WRITE_REGS) || (op == OP_WRITE_ANY);
	assign is_pgm = (op == OP_PAGE_PROG) || (op == OP_OTP_PROG);
	assign is_ers = (op == OP_SECT_ERASE);
	assign is_be  = (op == OP_BULK_ERASE);

	// Gated commands need the latch
	assign go = accept && (!(is_wr || is_pgm || is_ers || is_be)
		|| wel_q);

	// Lock with low protect pin drops status/config one writes
	assign wr_go = go && is_wr && !((op == OP_WRITE_REGS || cmd.to_sr1)
		&& status_write_lock_persistent && !wp_s2);

	// Status one write with volatile select touches only the level
	assign wr_vol = wr_go && (op == OP_WRITE_REGS || cmd.to_sr1)
		&& protect_bits_volatile_select;
	assign wr_nv  = wr_go && !wr_vol;

	// Protected program and sector erase targets turn into failures; a bulk erase under protection is dropped
	assign pgm_bad = (cmd.in_bp_range && (|prot_eff)) ||
		cmd.sect_locked || cmd.otp_locked;
	assign ers_bad = (cmd.in_bp_range && (|prot_eff)) ||
		cmd.sect_locked;
	assign pgm_go  = go && is_pgm && !pgm_bad;
	assign ers_go  = go && is_ers && !ers_bad;
	assign be_go   = go && is_be && (prot_eff == 3'h0);

	assign clr_stat = accept &&
		(op == OP_CLEAR_STAT_A || op == OP_CLEAR_STAT_B);
	assign soft_rst = accept && (op == OP_SOFT_RESET);
	assign done_ok  = (state_q == ST_RUN) && op_done && !op_fail;

	// ----------------------------------------------------------------
	// Lock mirror
	// ----------------------------------------------------------------
	// Follows the persistent bit every cycle; never written by commands
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lock_q <= RST_FLAG;
		end else begin
			lock_q <= status_write_lock_persistent;
		end
	end

	// ----------------------------------------------------------------
	// Failure flags
	// ----------------------------------------------------------------
	// Set wins over a clear in the same cycle; a failed persistent
	// register write counts as a program failure, so HOLD, except the
	// busy_default one after reset, always comes with a flag the host can see
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			p_err_q <= RST_FLAG;
		end else if ((go && is_pgm && pgm_bad) ||
			(state_q == ST_RUN && op_fail &&
			(kind_q == KIND_PROG || kind_q == KIND_REGW))) begin
			p_err_q <= 1'b1;
		end else if (clr_stat || soft_rst) begin
			p_err_q <= 1'b0;
		end
	end

	// Bulk erase skips of protected sectors are not failures
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			e_err_q <= RST_FLAG;
		end else if ((go && is_ers && ers_bad) ||
			(state_q == ST_RUN && op_fail && (kind_q == KIND_ERASE ||
			(kind_q == KIND_BULK && !op_prot_skip)))) begin
			e_err_q <= 1'b1;
		end else if (clr_stat || soft_rst) begin
			e_err_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Volatile protection level
	// ----------------------------------------------------------------
	// Loaded from the persistent copy once after reset, since an
	// asynchronous reset may only load constants
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prot_q <= RST_PROT;
		end else if (!init_q) begin
			prot_q <= protect_bits_persistent;
		end else if (wr_vol) begin
			prot_q <= cmd.data[POS_PROT_HI:POS_PROT_LO];
		end else if (!protect_bits_volatile_select) begin
			prot_q <= protect_bits_persistent;
		end
	end

	// ----------------------------------------------------------------
	// Write enable latch
	// ----------------------------------------------------------------
	// Volatile level writes clear this latch directly, persistent ones on successful completion
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wel_q <= RST_FLAG;
		end else if (soft_rst) begin
			wel_q <= 1'b0;
		end else if (accept && op == OP_LATCH_SET) begin
			wel_q <= 1'b1;
		end else if (accept && op == OP_LATCH_CLEAR) begin
			wel_q <= 1'b0;
		end else if (done_ok || wr_vol) begin
			wel_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Busy engine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			init_q <= RST_FLAG;
		end else begin
			init_q <= 1'b1;
		end
	end

	// A failure, or a blocked target, parks the engine in HOLD
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else if (!init_q) begin
			state_q <= busy_default ? ST_HOLD : ST_IDLE;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if ((go && is_pgm && pgm_bad) ||
					(go && is_ers && ers_bad)) begin
					state_q <= ST_HOLD;
				end else if (pgm_go || ers_go || be_go || wr_nv) begin
					state_q <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (op_done && op_fail && !(kind_q == KIND_BULK
					&& op_prot_skip)) begin
					state_q <= ST_HOLD;
				end else if (op_done || soft_rst) begin
					state_q <= ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (clr_stat || soft_rst) begin
					state_q <= ST_IDLE;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Operation launch
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			op_start  <= RST_FLAG;
			kind_q    <= KIND_PROG;
			op_data   <= RST_BYTE;
			op_to_sr1 <= RST_FLAG;
		end else begin
			op_start <= pgm_go || ers_go || be_go || wr_nv;
			if (pgm_go || ers_go || be_go || wr_nv) begin
				op_data   <= cmd.data;
				op_to_sr1 <= (op == OP_WRITE_REGS) || cmd.to_sr1;
				if (pgm_go) begin
					kind_q <= KIND_PROG;
				end else if (ers_go) begin
					kind_q <= KIND_ERASE;
				end else if (be_go) begin
					kind_q <= KIND_BULK;
				end else begin
					kind_q <= KIND_REGW;
				end
			end
		end
	end

	assign op_kind = kind_q;

	// ----------------------------------------------------------------
	// Suspend requests
	// ----------------------------------------------------------------
	// Only meaningful while the matching array operation runs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			susp_erase <= RST_FLAG;
			susp_prog  <= RST_FLAG;
		end else begin
			susp_erase <= accept && op == OP_ERASE_SUSP &&
				state_q == ST_RUN &&
				(kind_q == KIND_ERASE || kind_q == KIND_BULK);
			susp_prog  <= accept && op == OP_PROG_SUSP &&
				state_q == ST_RUN && kind_q == KIND_PROG;
		end
	end

	// ----------------------------------------------------------------
	// Answer and acknowledge
	// ----------------------------------------------------------------
	// Every command is acknowledged, ignored ones included, so the
	// link never stalls; status one reads carry the live register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sy_ack_q <= RST_FLAG;
			sy_rsp_q <= RST_BYTE;
		end else if (new_cmd) begin
			sy_ack_q <= sy_req_s2;
			if (accept && (op == OP_READ_STAT1 ||
				(op == OP_READ_ANY && cmd.to_sr1))) begin
				sy_rsp_q <= status1_volatile;
			end else begin
				sy_rsp_q <= RST_BYTE;
			end
		end
	end

endmodule

// ---- shared/fvs_pkg.sv ----
// Constants and carrier types for the volatile status-one block.
// Assumes a link front end that delivers whole decoded commands.
package fvs_pkg;

	// ----------------------------------------------------------------
	// Command opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_REGS   = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
	localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
	localparam logic [7:0] OP_READ_STAT1   = 8'h05;
	localparam logic [7:0] OP_LATCH_SET    = 8'h06;
	localparam logic [7:0] OP_READ_STAT2   = 8'h07;
	localparam logic [7:0] OP_CLEAR_STAT_A = 8'h30;
	localparam logic [7:0] OP_OTP_PROG     = 8'h42;
	localparam logic [7:0] OP_BULK_ERASE   = 8'h60;
	localparam logic [7:0] OP_READ_ANY     = 8'h65;
	localparam logic [7:0] OP_WRITE_ANY    = 8'h71;
	localparam logic [7:0] OP_ERASE_SUSP   = 8'h75;
	localparam logic [7:0] OP_CLEAR_STAT_B = 8'h82;
	localparam logic [7:0] OP_PROG_SUSP    = 8'h85;
	localparam logic [7:0] OP_SECT_ERASE   = 8'hD8;
	localparam logic [7:0] OP_SOFT_RESET   = 8'hF0;

	// ----------------------------------------------------------------
	// Status one field positions
	// ----------------------------------------------------------------
	localparam int POS_LOCK    = 7;
	localparam int POS_P_ERR   = 6;
	localparam int POS_E_ERR   = 5;
	localparam int POS_PROT_HI = 4;
	localparam int POS_PROT_LO = 2;
	localparam int POS_WEL     = 1;
	localparam int POS_BUSY    = 0;

	// Reset values of the volatile fields
	localparam logic       RST_FLAG = 1'b0;
	localparam logic [2:0] RST_PROT = 3'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Command as handed over by the link front end
	typedef struct packed {
		logic [7:0] op;          // Opcode
		logic [7:0] data;        // First data byte
		logic       to_sr1;      // Register write aims at status/config one
		logic       in_bp_range; // Address inside the block-protected range
		logic       sect_locked; // Sector individually protected
		logic       otp_locked;  // One-time region locked
	} fvs_cmd_t;

	// Kind of embedded operation started
	typedef enum logic [1:0] {
		KIND_PROG,
		KIND_ERASE,
		KIND_BULK,
		KIND_REGW
	} fvs_kind_t;

	// Busy engine states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_HOLD
	} fvs_state_t;

endpackage

// ---- verif/fvs_chk.sv ----
// Port checker for the volatile status-one block.
// Assumes persistent inputs hold still across reset release.
`timescale 1ns/1ns
module fvs_chk
	import fvs_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       status_write_lock_persistent,
	input wire logic [2:0] protect_bits_persistent,
	input wire logic       protect_bits_volatile_select,
	input wire logic       op_done,
	input wire logic       op_fail,
	input wire logic       op_prot_skip,
	input wire logic       op_start,
	input wire fvs_kind_t  op_kind,
	input wire logic       susp_erase,
	input wire logic       susp_prog,
	input wire logic [2:0] protect_active,
	input wire logic [7:0] status1_volatile
);
	// ----------------------------------------
	// Aliases and defaults, one clock domain
	// ----------------------------------------
	logic [7:0] s;  // Status byte
	logic       lk; // Persistent lock
	logic [2:0] pb; // Persistent level
	assign s  = status1_volatile;
	assign lk = status_write_lock_persistent;
	assign pb = protect_bits_persistent;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_LOCK_COPY: assert property (
		$past(rst_n) && lk == $past(lk) && lk == $past(lk, 2)
		|-> s[7] == lk
	) else $error("lock copy differs from persistent bit");
	AST_FAIL_HOLD: assert property (
		op_done && op_fail && op_kind != KIND_BULK |=> s[0] && (s[6] || s[5])
	) else $error("failure did not hold busy with a flag");
	AST_BULK_SKIP: assert property (
		op_done && op_prot_skip && op_kind == KIND_BULK && !s[5] |=> !s[5]
	) else $error("bulk erase skip raised erase flag");
	AST_DONE_CLR: assert property (
		op_done && !op_fail |=> !s[1] && !s[0]
	) else $error("success left latch or busy set");
	AST_START_BUSY: assert property (
		op_start |-> s[0] && $past(s[1])
	) else $error("launch without latch or busy");
	AST_BULK_PROT: assert property (
		op_start && op_kind == KIND_BULK |-> protect_active == 3'h0
	) else $error("bulk erase launched under protection");
	AST_SUSP_E: assert property (
		susp_erase |-> s[0] && op_kind inside {KIND_ERASE, KIND_BULK}
	) else $error("erase suspend outside erase");
	AST_SUSP_P: assert property (
		susp_prog |-> s[0] && op_kind == KIND_PROG
	) else $error("program suspend outside program");
	AST_PROT_VOL: assert property (
		protect_bits_volatile_select |-> protect_active == s[4:2]
	) else $error("volatile level not in force");
	AST_PROT_PER: assert property (
		!protect_bits_volatile_select && $stable(protect_bits_volatile_select)
		&& $stable(pb) && $past(rst_n) |-> s[4:2] == pb
	) else $error("volatile copy not following persistent level");
endmodule

bind fvs_status_one fvs_chk chk_u (
	.clk_sys, .rst_n, .status_write_lock_persistent,
	.protect_bits_persistent, .protect_bits_volatile_select,
	.op_done, .op_fail, .op_prot_skip, .op_start, .op_kind,
	.susp_erase, .susp_prog, .protect_active, .status1_volatile
);

// ---- verif/fvs_host_model.sv ----
// Host command issuer on the link port of the status-one block.
// Assumes the caller waits for each answer before the next command.
`timescale 1ns/1ns
module fvs_host_model
	import fvs_pkg::*;
(
	input  wire logic       clk_link,
	input  wire logic       cmd_ready,
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_data,
	output logic            cmd_valid,
	output fvs_cmd_t        cmd_in
);
	// ----------------------------------------
	// Command transfer
	// ----------------------------------------
	initial begin
		cmd_valid = 1'b0;
		cmd_in = '0;
	end

	// Offer held until taken, then wait for the single answer byte
	task automatic xfer(input fvs_cmd_t c, output logic [7:0] r,
		output logic ok);
		int n;
		ok = 1'b0;
		@(posedge clk_link);
		cmd_valid <= 1'b1;
		cmd_in    <= c;
		for (n = 0; n < 100 && !ok; n++) begin
			@(posedge clk_link);
			ok = cmd_ready;
		end
		// Released lines show the inverse, not a stale copy
		cmd_valid <= 1'b0;
		cmd_in    <= ~c;
		for (n = 0; n < 100 && ok; n++) begin
			@(posedge clk_link);
			if (rsp_valid) break;
		end
		ok = ok && rsp_valid;
		r  = rsp_data;
	endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the volatile status-one block.
// Assumes the host model sends commands; the bench is the array engine.
`timescale 1ns/1ns
module tb;
	import fvs_pkg::*;
	// ----------------------------------------
	// Signals, tables and counters
	// ----------------------------------------
	logic       clk_sys = 1'b0;  // 100 ns period
	logic       clk_link = 1'b0; // 30 ns period
	logic       rst_n = 1'b0;
	logic       cmd_valid, cmd_ready, rsp_valid, op_start, op_to_sr1;
	logic       susp_erase, susp_prog, ok, last_sr1;
	logic       busy_default = 1'b0; // Factory busy default
	fvs_cmd_t   cmd_in;
	logic [7:0] rsp_data, op_data, status1_volatile, rsp, last_data;
	logic       status_write_lock_persistent = 1'b0;
	logic [2:0] protect_bits_persistent = 3'h0;
	logic       protect_bits_volatile_select = 1'b0;
	logic       wp_n_pin = 1'b1;
	logic       op_done = 1'b0;
	logic       op_fail = 1'b0;
	logic       op_prot_skip = 1'b0;
	fvs_kind_t  op_kind, last_kind;
	logic [2:0] protect_active;
	int         err_total = 0, tests_run = 0, i;
	int         n_start = 0, n_se = 0, n_sp = 0;
	// Refused targets: opcode, flags, flag raised, clearing opcode
	logic [7:0] f_op [4] = '{OP_PAGE_PROG, OP_OTP_PROG, OP_SECT_ERASE,
		OP_SECT_ERASE};
	logic [3:0] f_fl [4] = '{4'h4, 4'h1, 4'h2, 4'h4};
	logic [7:0] f_er [4] = '{8'h40, 8'h40, 8'h20, 8'h20};
	logic [7:0] f_cl [4] = '{OP_CLEAR_STAT_A, OP_CLEAR_STAT_B,
		OP_CLEAR_STAT_A, OP_CLEAR_STAT_B};
	logic [7:0] w_op [2] = '{OP_WRITE_REGS, OP_WRITE_ANY};
	logic [7:0] w_d [2] = '{8'h08, 8'h00};

	initial forever #50 clk_sys = ~clk_sys;
	initial begin
		#7;
		forever #15 clk_link = ~clk_link;
	end

	fvs_status_one dut_u (.clk_sys, .rst_n, .clk_link, .cmd_valid,
		.cmd_in, .cmd_ready, .rsp_valid, .rsp_data,
		.status_write_lock_persistent, .protect_bits_persistent,
		.protect_bits_volatile_select, .busy_default, .wp_n_pin,
		.op_done, .op_fail, .op_prot_skip, .op_start, .op_kind, .op_data,
		.op_to_sr1, .susp_erase, .susp_prog, .protect_active,
		.status1_volatile);
	fvs_host_model host_u (.clk_link, .cmd_ready, .rsp_valid, .rsp_data,
		.cmd_valid, .cmd_in);

	// Launches and suspends seen on the engine side
	always @(posedge clk_sys) begin
		if (op_start) begin
			n_start++;
			last_kind = op_kind;
			last_data = op_data;
			last_sr1 = op_to_sr1;
		end
		if (susp_erase) n_se++;
		if (susp_prog) n_sp++;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g, input logic [7:0] m = 8'hFF);
		tests_run++;
		if ((g & m) !== (e & m)) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	// A lost handshake ends the run
	task automatic send(input logic [7:0] op, input logic [7:0] d = 8'h00,
		input logic [3:0] f = 4'h0);
		host_u.xfer(fvs_cmd_t'({op, d, f}), rsp, ok);
		if (!ok) begin
			err_total++;
			results();
		end
	endtask

	task automatic rd(input logic [7:0] e, input logic [7:0] m = 8'hFF);
		send(OP_READ_STAT1);
		chk("status", e, rsp, m);
	endtask

	// Engine report, one cycle wide
	task automatic fin(input logic f, input logic s);
		@(posedge clk_sys);
		op_done      <= 1'b1;
		op_fail      <= f;
		op_prot_skip <= s;
		@(posedge clk_sys);
		op_done      <= 1'b0;
		op_fail      <= 1'b0;
		op_prot_skip <= 1'b0;
	endtask

	// Covers the two-flop pin synchroniser and launch latency
	task automatic settle();
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic do_reset();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		do_reset();
		rd(8'h00);
		send(OP_PAGE_PROG);
		send(OP_SECT_ERASE);
		send(OP_LATCH_SET);
		rd(8'h02);
		send(OP_LATCH_CLEAR);
		rd(8'h00);
		chk("starts", 8'h00, n_start[7:0]);
		$display("test latch done");
		@(posedge clk_sys) protect_bits_persistent <= 3'h1;
		settle();
		send(OP_LATCH_SET);
		send(OP_BULK_ERASE);
		rd(8'h06);
		for (i = 0; i < 4; i++) begin
			send(OP_LATCH_SET);
			send(f_op[i], 8'h00, f_fl[i]);
			rd(f_er[i] | 8'h05, 8'hFD);
			send(f_cl[i]);
			send(OP_LATCH_CLEAR);
			rd(8'h04);
		end
		chk("starts", 8'h00, n_start[7:0]);
		$display("test refusals done");
		for (i = 0; i < 2; i++) begin
			send(OP_LATCH_SET);
			send(w_op[i], w_d[i], 4'h8);
			settle();
			chk("kind", 8'h03, {6'h00, last_kind});
			chk("wdata", w_d[i], last_data);
			chk("sr1", 8'h01, {7'h00, last_sr1});
			send(OP_LATCH_CLEAR);
			rd({3'h0, protect_bits_persistent, 2'h3});
			fin(1'b0, 1'b0);
			@(posedge clk_sys) protect_bits_persistent <= w_d[i][4:2];
			settle();
			rd(w_d[i] & 8'h1C);
		end
		$display("test persistent done");
		@(posedge clk_sys) protect_bits_volatile_select <= 1'b1;
		settle();
		send(OP_LATCH_SET);
		send(OP_WRITE_REGS, 8'hFF, 4'h8);
		rd(8'h1C);
		chk("level", 8'h07, {5'h00, protect_active});
		chk("starts", 8'h02, n_start[7:0]);
		send(OP_LATCH_SET);
		send(OP_BULK_ERASE);
		rd(8'h1E);
		@(posedge clk_sys) status_write_lock_persistent <= 1'b1;
		wp_n_pin <= 1'b0;
		settle();
		send(OP_WRITE_REGS, 8'h00, 4'h8);
		rd(8'h9E);
		@(posedge clk_sys) wp_n_pin <= 1'b1;
		settle();
		send(OP_WRITE_REGS, 8'h00, 4'h8);
		rd(8'h80);
		$display("test volatile done");
		send(OP_LATCH_SET);
		send(OP_PAGE_PROG);
		send(OP_ERASE_SUSP);
		send(OP_PROG_SUSP);
		fin(1'b0, 1'b0);
		rd(8'h80);
		send(OP_LATCH_SET);
		send(OP_BULK_ERASE);
		send(OP_PROG_SUSP);
		fin(1'b1, 1'b1);
		rd(8'h80, 8'hFD);
		send(OP_LATCH_SET);
		send(OP_SECT_ERASE);
		send(OP_ERASE_SUSP);
		fin(1'b1, 1'b0);
		rd(8'hA1, 8'hFD);
		send(OP_CLEAR_STAT_B);
		send(OP_LATCH_CLEAR);
		rd(8'h80);
		chk("psusp", 8'h01, n_sp[7:0]);
		chk("esusp", 8'h01, n_se[7:0]);
		send(OP_LATCH_SET);
		send(OP_SOFT_RESET);
		rd(8'h80);
		send(OP_LATCH_SET);
		@(posedge clk_sys) busy_default <= 1'b1;
		do_reset();
		send(OP_LATCH_SET);
		rd(8'h81);
		send(OP_CLEAR_STAT_A);
		rd(8'h80);
		$display("test runs done");
		results();
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		results();
	end
endmodule
